//--- umfc_params.svh
// Register offsets, field positions, reset values and counts for the modem and queue control block.
`ifndef UMFC_PARAMS_SVH
`define UMFC_PARAMS_SVH
`define UMFC_ADDR_W 5
`define UMFC_OFS_IIR_FCR 5'h08
`define UMFC_OFS_MCR 5'h10
`define UMFC_OFS_MSR 5'h18
`define UMFC_OFS_SCR 5'h1C
`define UMFC_MCR_DTR 0
`define UMFC_MCR_RTS 1
`define UMFC_MCR_LOOP 4
`define UMFC_MCR_RESET 3'h0
`define UMFC_MSR_DCTS 0
`define UMFC_MSR_DDSR 1
`define UMFC_MSR_TERI 2
`define UMFC_MSR_DDCD 3
`define UMFC_MSR_FLAGS_RESET 4'h0
`define UMFC_FCR_EN 0
`define UMFC_FCR_RXCLR 1
`define UMFC_FCR_TXCLR 2
`define UMFC_FCR_TRIG_LO 6
`define UMFC_FCR_TRIG_HI 7
`define UMFC_FIFO_MODE_ON 2'h3
`define UMFC_FIFO_MODE_OFF 2'h0
`define UMFC_TRIG_RESET 2'h0
`define UMFC_TRIG_LVL_00 5'h01
`define UMFC_TRIG_LVL_01 5'h08
`define UMFC_TRIG_LVL_10 5'h04
`define UMFC_TRIG_LVL_11 5'h0E
`define UMFC_TIMEOUT_CHARS 4
`define UMFC_CNT_W 5
`endif

//--- umfc_pkg.sv
// Types shared by the modem and queue control block.
package umfc_pkg;
  // Interrupt identification codes, highest priority first.
  typedef enum logic [3:0] {
    UMFC_IRQ_LINE = 4'h6,
    UMFC_IRQ_RXDATA = 4'h4,
    UMFC_IRQ_TIMEOUT = 4'hC,
    UMFC_IRQ_THRE = 4'h2,
    UMFC_IRQ_MODEM = 4'h0,
    UMFC_IRQ_NONE = 4'h1
  } umfc_irq_code_t;
  // One register byte.
  typedef logic [7:0] umfc_byte_t;
endpackage

//--- umfc_pin_if.sv
// Carrier between a sideband edge detector and the control block.
`timescale 1ns/10ps
interface umfc_pin_if;
  // Present level of the sampled pin.
  logic level;
  // One-cycle pulse when the watched edge is seen.
  logic change;
  modport det (output level, output change);
  modport user (input level, input change);
endinterface

//--- umfc_edge_detect.sv
// Edge detector for one modem sideband input.
`timescale 1ns/10ps
module umfc_edge_detect #(
  parameter bit FALL_ONLY = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  umfc_pin_if.det pout
);
  // Previous sample of the pin.
  logic prev;
  // Low until the first sample after reset, so a pin resting high is no change.
  logic primed;

  //////////////////////////////////////////////////////////////////////////////
  // Sample history; reset clears the previous level and the primed flag, then each clock loads them.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev <= 1'b0;
      primed <= 1'b0;
    end else begin
      prev <= pin;
      primed <= 1'b1;
    end
  end

  assign pout.level = pin;
  assign pout.change = primed && (FALL_ONLY ? (prev && !pin) : (prev != pin));

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the edge detector.
  chk_rising_ignored: assert property (@(posedge clk) disable iff (!rst_b)
    (FALL_ONLY && primed && pin && !prev) |-> !pout.change)
    else $error("Rising edge flagged on a falling-only input.");
  chk_edge_seen: assert property (@(posedge clk) disable iff (!rst_b)
    (!FALL_ONLY && $past(primed) && primed && (pin != $past(pin))) |-> pout.change)
    else $error("Input change was not detected.");
endmodule

//--- umfc_top.sv
// Modem sideband, loopback, interrupt identification and queue control registers.
// Operation
// - Control bit 4 loops transmitter into receiver.
// - RTS pin follows control bit 1.
// - DTR pin follows control bit 0.
// - Reset clears the whole modem control register.
// - Status bits 7..4 show DCD, RI, DSR, CTS.
// - DCD, DSR, CTS changes set bits 3,1,0.
// - Only falling RI sets status bit 2.
// - Status read-only; change bits reset to zero.
// - Identification read and queue control share address.
// - Bits 7:6 read 00 off, 11 on.
// - Control bits 7:6 pick receive threshold.
// - Bit 2 flushes transmit queue, self-clearing.
// - Bit 1 flushes receive queue, self-clearing.
// - Bit 0 enables both queues together.
// - Clearing enable flushes both queues.
// - Other control bits need enable bit set.
// - Eight-bit scratch byte, not reset.
// - Bits 3:0 encode highest pending interrupt.
// - Timeout after four idle character times.
// - Modem status read clears modem interrupt.
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
`include "umfc_params.svh"
module umfc_top #(
  parameter int TIMEOUT_CHARS = `UMFC_TIMEOUT_CHARS
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [`UMFC_ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic TX_SERIAL,
  output logic RX_SERIAL,
  input wire logic SIN,
  output logic SOUT,
  output logic RTS,
  output logic DTR,
  input wire logic CTS,
  input wire logic DSR,
  input wire logic RI,
  input wire logic DCD,
  input wire logic LSR_IRQ,
  input wire logic THRE_IRQ,
  input wire logic [`UMFC_CNT_W-1:0] RX_COUNT,
  input wire logic RX_MOVED,
  input wire logic CHAR_TICK,
  output logic FIFO_ENABLE,
  output logic [`UMFC_CNT_W-1:0] RX_THRESHOLD,
  output logic TX_FLUSH,
  output logic RX_FLUSH,
  output logic IIR_READ_THRE,
  output logic [3:0] IRQ_CODE
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration check: the idle counter is three bits wide.
  if (TIMEOUT_CHARS < 1 || TIMEOUT_CHARS > 7) begin : g_bad_timeout
    $error("TIMEOUT_CHARS must lie between 1 and 7.");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.
  // High during the second cycle of a request, when the answer is given.
  logic ack;
  // A request completes at this edge.
  logic done_rd;
  logic done_wr;
  // Address decode of the current request.
  logic hit_fcr;
  logic hit_mcr;
  logic hit_msr;
  logic hit_scr;
  // Low byte lane is written.
  logic lane0;
  // Modem control bits: loop, RTS, DTR.
  logic loop_en;
  logic rts_bit;
  logic dtr_bit;
  // Change flags, bits 3..0 of the modem status readout.
  logic [3:0] msr_flags;
  logic [3:0] next_msr_flags;
  // Queue control state.
  logic fifo_en;
  logic [1:0] rx_threshold_select;
  // Scratch byte, deliberately without reset.
  umfc_pkg::umfc_byte_t scratch_byte;
  // Character-time idle counter for the receive timeout.
  logic [2:0] idle_chars;
  logic timeout_pend;
  logic rx_avail;
  // Highest-priority pending interrupt.
  umfc_pkg::umfc_irq_code_t interrupt_source_code;
  // Readout mux.
  logic [31:0] rd_mux;

  // One detector per sideband input, joined by the carrier interface.
  umfc_pin_if p_cts ();
  umfc_pin_if p_dsr ();
  umfc_pin_if p_ri ();
  umfc_pin_if p_dcd ();

  umfc_edge_detect #(.FALL_ONLY(1'b0)) u_cts (.clk(CLK), .rst_b(RST_B), .pin(CTS), .pout(p_cts));
  umfc_edge_detect #(.FALL_ONLY(1'b0)) u_dsr (.clk(CLK), .rst_b(RST_B), .pin(DSR), .pout(p_dsr));
  umfc_edge_detect #(.FALL_ONLY(1'b1)) u_ri (.clk(CLK), .rst_b(RST_B), .pin(RI), .pout(p_ri));
  umfc_edge_detect #(.FALL_ONLY(1'b0)) u_dcd (.clk(CLK), .rst_b(RST_B), .pin(DCD), .pout(p_dcd));

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake: every request waits exactly one cycle, so the read data can
  // be captured in a flop before the answer edge.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack <= 1'b0;
    end else begin
      ack <= (READ || WRITE) && !ack;
    end
  end

  assign WAITREQUEST = (READ || WRITE) && !ack;
  assign done_rd = READ && ack;
  assign done_wr = WRITE && ack;
  // one address, read and write go to different registers.
  assign hit_fcr = (ADDRESS == `UMFC_OFS_IIR_FCR);
  assign hit_mcr = (ADDRESS == `UMFC_OFS_MCR);
  assign hit_msr = (ADDRESS == `UMFC_OFS_MSR);
  assign hit_scr = (ADDRESS == `UMFC_OFS_SCR);
  assign lane0 = BYTEENABLE[0];

  //////////////////////////////////////////////////////////////////////////////
  // Modem control register.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {loop_en, rts_bit, dtr_bit} <= `UMFC_MCR_RESET;
    end else if (done_wr && hit_mcr && lane0) begin
      // bits 3:2 and 31:5 are not stored.
      loop_en <= WRITEDATA[`UMFC_MCR_LOOP];
      rts_bit <= WRITEDATA[`UMFC_MCR_RTS];
      dtr_bit <= WRITEDATA[`UMFC_MCR_DTR];
    end
  end

  assign RTS = rts_bit;
  assign DTR = dtr_bit;
  // loopback; the line idles at mark so the far end sees no traffic.
  assign RX_SERIAL = loop_en ? TX_SERIAL : SIN;
  assign SOUT = loop_en ? 1'b1 : TX_SERIAL;

  //////////////////////////////////////////////////////////////////////////////
  // Change flags: a new edge in the very cycle of the clearing read survives.
  always_comb begin
    next_msr_flags = msr_flags;
    // completed read of the status register clears the flags.
    if (done_rd && hit_msr) begin
      next_msr_flags = `UMFC_MSR_FLAGS_RESET;
    end
    // changes on carrier, data-set-ready and clear-to-send, and falling edges of ring indicator.
    next_msr_flags[`UMFC_MSR_DCTS] = next_msr_flags[`UMFC_MSR_DCTS] | p_cts.change;
    next_msr_flags[`UMFC_MSR_DDSR] = next_msr_flags[`UMFC_MSR_DDSR] | p_dsr.change;
    next_msr_flags[`UMFC_MSR_DDCD] = next_msr_flags[`UMFC_MSR_DDCD] | p_dcd.change;
    next_msr_flags[`UMFC_MSR_TERI] = next_msr_flags[`UMFC_MSR_TERI] | p_ri.change;
  end

  // flags start at zero; no write path exists.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      msr_flags <= `UMFC_MSR_FLAGS_RESET;
    end else begin
      msr_flags <= next_msr_flags;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Queue control: enable, threshold and self-clearing flush pulses.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fifo_en <= 1'b0;
      rx_threshold_select <= `UMFC_TRIG_RESET;
    end else if (done_wr && hit_fcr && lane0) begin
      fifo_en <= WRITEDATA[`UMFC_FCR_EN];
      // the threshold only moves when the enable bit is written as 1.
      if (WRITEDATA[`UMFC_FCR_EN]) begin
        rx_threshold_select <= WRITEDATA[`UMFC_FCR_TRIG_HI:`UMFC_FCR_TRIG_LO];
      end
    end
  end

  // Flush pulses last one cycle, which is what makes the bits self-clearing.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_FLUSH <= 1'b0;
      RX_FLUSH <= 1'b0;
    end else if (done_wr && hit_fcr && lane0) begin
      TX_FLUSH <= WRITEDATA[`UMFC_FCR_EN] ? WRITEDATA[`UMFC_FCR_TXCLR] : fifo_en;
      RX_FLUSH <= WRITEDATA[`UMFC_FCR_EN] ? WRITEDATA[`UMFC_FCR_RXCLR] : fifo_en;
    end else begin
      TX_FLUSH <= 1'b0;
      RX_FLUSH <= 1'b0;
    end
  end

  assign FIFO_ENABLE = fifo_en;

  // Threshold in bytes for the receive path.
  always_comb begin
    unique case (rx_threshold_select)
      2'h0: RX_THRESHOLD = `UMFC_TRIG_LVL_00;
      2'h1: RX_THRESHOLD = `UMFC_TRIG_LVL_01;
      2'h2: RX_THRESHOLD = `UMFC_TRIG_LVL_10;
      2'h3: RX_THRESHOLD = `UMFC_TRIG_LVL_11;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Scratch byte: no reset, so it costs no reset routing.
  always_ff @(posedge CLK) begin
    if (done_wr && hit_scr && lane0) begin
      scratch_byte <= WRITEDATA[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive timeout: count character times while bytes sit untouched.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      idle_chars <= 3'h0;
    end else if (!fifo_en || RX_COUNT == '0 || RX_MOVED) begin
      idle_chars <= 3'h0;
    end else if (CHAR_TICK && !timeout_pend) begin
      idle_chars <= idle_chars + 3'h1;
    end
  end

  assign timeout_pend = (idle_chars == 3'(TIMEOUT_CHARS));
  // Without the queues one byte is enough.
  assign rx_avail = fifo_en ? (RX_COUNT >= RX_THRESHOLD) : (RX_COUNT != '0);

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt priority encoder.
  always_comb begin
    if (LSR_IRQ) begin
      interrupt_source_code = umfc_pkg::UMFC_IRQ_LINE;
    end else if (rx_avail) begin
      interrupt_source_code = umfc_pkg::UMFC_IRQ_RXDATA;
    end else if (timeout_pend) begin
      interrupt_source_code = umfc_pkg::UMFC_IRQ_TIMEOUT;
    end else if (THRE_IRQ) begin
      interrupt_source_code = umfc_pkg::UMFC_IRQ_THRE;
    end else if (msr_flags != `UMFC_MSR_FLAGS_RESET) begin
      // pending until the status read clears the flags.
      interrupt_source_code = umfc_pkg::UMFC_IRQ_MODEM;
    end else begin
      interrupt_source_code = umfc_pkg::UMFC_IRQ_NONE;
    end
  end

  assign IRQ_CODE = interrupt_source_code;
  // Tells the transmit path that software has seen its empty interrupt.
  assign IIR_READ_THRE = done_rd && hit_fcr && (interrupt_source_code == umfc_pkg::UMFC_IRQ_THRE);

  //////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the waiting cycle and held through the answer.
  always_comb begin
    // unused bits and unmapped offsets read zero.
    rd_mux = 32'h0000_0000;
    if (hit_mcr) begin
      rd_mux[`UMFC_MCR_LOOP] = loop_en;
      rd_mux[`UMFC_MCR_RTS] = rts_bit;
      rd_mux[`UMFC_MCR_DTR] = dtr_bit;
    end else if (hit_msr) begin
      // live pin levels above the flags.
      rd_mux[7:0] = {p_dcd.level, p_ri.level, p_dsr.level, p_cts.level, msr_flags};
    end else if (hit_fcr) begin
      rd_mux[7:6] = fifo_en ? `UMFC_FIFO_MODE_ON : `UMFC_FIFO_MODE_OFF;
      rd_mux[3:0] = interrupt_source_code;
    end else if (hit_scr) begin
      rd_mux[7:0] = scratch_byte;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      READDATA <= 32'h0000_0000;
    end else if (READ && !ack) begin
      READDATA <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  chk_loop_route: assert property (
    (done_wr && hit_mcr && lane0 && WRITEDATA[4]) |=> (RX_SERIAL == TX_SERIAL) && SOUT)
    else $error("Loopback did not route transmitter to receiver.");
  chk_rts_follow: assert property (
    (done_wr && hit_mcr && lane0) |=> (RTS == $past(WRITEDATA[1])))
    else $error("RTS does not follow the written bit.");
  chk_dtr_follow: assert property (
    (done_wr && hit_mcr && lane0) |=> (DTR == $past(WRITEDATA[0])))
    else $error("DTR does not follow the written bit.");
  chk_mcr_reset: assert property (
    $rose(RST_B) |-> (!RTS && !DTR && !loop_en))
    else $error("Modem control not cleared by reset.");
  chk_msr_pins: assert property (
    (done_rd && hit_msr) |-> (READDATA[7:4] == $past({DCD, RI, DSR, CTS})))
    else $error("Modem status upper nibble does not show the pins.");
  chk_cts_flag: assert property (
    p_cts.change |=> msr_flags[0])
    else $error("CTS change did not set its flag.");
  chk_msr_clear: assert property (
    (done_rd && hit_msr && !p_cts.change && !p_dsr.change && !p_ri.change && !p_dcd.change)
    |=> (msr_flags == 4'h0))
    else $error("Status read did not clear the change flags.");
  chk_mode_bits: assert property (
    (done_rd && hit_fcr) |-> (READDATA[7:6] == {2{fifo_en}}))
    else $error("Mode indicator wrong.");
  chk_tx_flush: assert property (
    (done_wr && hit_fcr && lane0 && WRITEDATA[0] && WRITEDATA[2]) |=> TX_FLUSH ##1 !TX_FLUSH)
    else $error("Transmit flush is not a single pulse.");
  chk_disable_flush: assert property (
    (done_wr && hit_fcr && lane0 && fifo_en && !WRITEDATA[0]) |=> (TX_FLUSH && RX_FLUSH && !FIFO_ENABLE))
    else $error("Disabling the queues did not flush both.");
  chk_thr_gated: assert property (
    (done_wr && hit_fcr && !WRITEDATA[0]) |=> $stable(rx_threshold_select))
    else $error("Threshold changed without the enable bit.");
  chk_timeout_cause: assert property (
    (interrupt_source_code == umfc_pkg::UMFC_IRQ_TIMEOUT) |-> (fifo_en && RX_COUNT != '0))
    else $error("Timeout reported without queued bytes.");
  chk_mcr_reserved: assert property (
    (done_rd && hit_mcr) |-> (READDATA[31:5] == '0 && READDATA[3:2] == 2'h0))
    else $error("Reserved modem control bits read non-zero.");

  cov_loop_on: cover property (done_wr && hit_mcr && WRITEDATA[4]);
  cov_ri_fall: cover property (p_ri.change ##[1:20] (done_rd && hit_msr));
  cov_timeout: cover property (interrupt_source_code == umfc_pkg::UMFC_IRQ_TIMEOUT);
  cov_disable: cover property (done_wr && hit_fcr && fifo_en && !WRITEDATA[0]);
endmodule

//--- umfc_modem_model.sv
// Behavioural modem on the sideband pins, with an optional late flow-control echo.
`timescale 1ns/10ps
module umfc_modem_model (
  input wire logic clk,
  input wire logic rts,
  input wire logic dtr,
  output logic cts,
  output logic dsr,
  output logic ri,
  output logic dcd,
  output logic sin
);
  // Echo delay in cycles; zero leaves every status line to the bench.
  int lag = 0;
  // Recent history of the request line, so a slow modem can answer late.
  logic [7:0] rts_hist = 8'h00;
  // The serial line idles high and the status lines start inactive.
  initial begin
    {dcd, ri, dsr, cts, sin} = 5'h01;
  end
  //////////////////////////////////////////////////////////////////////////////
  // A real modem answers flow control some cycles late, which the bench must tolerate.
  always @(posedge clk) begin
    rts_hist <= {rts_hist[6:0], rts};
    if (lag > 0) begin
      cts <= rts_hist[lag-1];
      dsr <= dtr;
    end
  end
  // Changes the status lines just after the next edge, DCD in the top bit.
  task set_lines(input logic [3:0] v);
    @(posedge clk);
    {dcd, ri, dsr, cts} <= v;
  endtask
endmodule

//--- tb_umfc_top.sv
// Self-checking bench for the modem and queue control registers.
`timescale 1ns/10ps
`include "umfc_params.svh"
module tb_umfc_top;
  // A short timeout count keeps the idle-character scenario brief.
  localparam int TCH = 3;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [`UMFC_ADDR_W-1:0] ADDRESS = '0;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = '0;
  logic [3:0] BYTEENABLE = 4'hF;
  logic TX_SERIAL = 1'b1;
  logic LSR_IRQ = 1'b0;
  logic THRE_IRQ = 1'b0;
  logic [`UMFC_CNT_W-1:0] RX_COUNT = '0;
  logic RX_MOVED = 1'b0;
  logic CHAR_TICK = 1'b0;
  logic [31:0] READDATA;
  logic WAITREQUEST, RX_SERIAL, SIN, SOUT, RTS, DTR, CTS, DSR, RI, DCD;
  logic FIFO_ENABLE, TX_FLUSH, RX_FLUSH, IIR_READ_THRE;
  logic [`UMFC_CNT_W-1:0] RX_THRESHOLD;
  logic [3:0] IRQ_CODE;
  // Counters, random seed and the queue of expected read data.
  int error_cnt = 0;
  int total_checks = 0;
  int cyc_cnt = 0;
  integer seed = 32'hd51d633e;
  logic [31:0] exp_q[$];
  logic [31:0] w;
  logic [4:0] thr[4] = '{5'h01, 5'h08, 5'h04, 5'h0E};

  initial begin
    forever #4 CLK = ~CLK;
  end

  umfc_top #(.TIMEOUT_CHARS(TCH)) umfc_top_i (.CLK(CLK), .RST_B(RST_B), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .TX_SERIAL(TX_SERIAL), .RX_SERIAL(RX_SERIAL), .SIN(SIN), .SOUT(SOUT),
    .RTS(RTS), .DTR(DTR), .CTS(CTS), .DSR(DSR), .RI(RI), .DCD(DCD), .LSR_IRQ(LSR_IRQ), .THRE_IRQ(THRE_IRQ),
    .RX_COUNT(RX_COUNT), .RX_MOVED(RX_MOVED), .CHAR_TICK(CHAR_TICK), .FIFO_ENABLE(FIFO_ENABLE),
    .RX_THRESHOLD(RX_THRESHOLD), .TX_FLUSH(TX_FLUSH), .RX_FLUSH(RX_FLUSH), .IIR_READ_THRE(IIR_READ_THRE),
    .IRQ_CODE(IRQ_CODE));

  umfc_modem_model umfc_modem_model_i (.clk(CLK), .rts(RTS), .dtr(DTR), .cts(CTS), .dsr(DSR), .ri(RI),
    .dcd(DCD), .sin(SIN));

  //////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task check(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  // Prints the verdict and ends the run; the only place the run stops.
  task results;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One bus request, held until waitrequest is seen low at a rising edge.
  task xfer(input logic is_rd, input logic [`UMFC_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDRESS <= a;
    READ <= is_rd;
    WRITE <= !is_rd;
    if (!is_rd) WRITEDATA <= d;
    if (is_rd) exp_q.push_back(d);
    // Waitrequest is sampled at each rising edge; the edge that sees it low is the answer edge.
    do @(posedge CLK); while (WAITREQUEST !== 1'b0);
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask

  task rd(input logic [`UMFC_ADDR_W-1:0] a, input logic [31:0] e);
    xfer(1'b1, a, e);
  endtask

  task wr(input logic [`UMFC_ADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b0, a, d);
  endtask

  // Drives the interrupt sources, lets them settle, then checks the code.
  task irq(input logic l, input logic t, input logic [4:0] c, input logic [3:0] e);
    @(posedge CLK);
    LSR_IRQ <= l;
    THRE_IRQ <= t;
    RX_COUNT <= c;
    @(posedge CLK);
    @(negedge CLK);
    check({28'h0, IRQ_CODE}, {28'h0, e});
  endtask

  // One character-time pulse.
  task tick;
    @(posedge CLK);
    CHAR_TICK <= 1'b1;
    @(posedge CLK);
    CHAR_TICK <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Read data are taken at the answer edge, the rising edge at which waitrequest is seen low.
  always @(posedge CLK) begin
    if (READ === 1'b1 && WAITREQUEST === 1'b0) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
      end else begin
        check(READDATA, exp_q[0]);
        if (ADDRESS == `UMFC_OFS_IIR_FCR) check({31'h0, IIR_READ_THRE}, {31'h0, exp_q[0][3:0] == 4'h2});
        void'(exp_q.pop_front());
      end
    end
  end

  // Cuts a hang short well beyond the length of the sequence.
  always @(posedge CLK) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      results();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge CLK);
    RST_B <= 1'b1;
    // Reset values, and an unmapped address that must read zero.
    rd(`UMFC_OFS_MCR, 32'h0);
    rd(`UMFC_OFS_MSR, 32'h0);
    rd(`UMFC_OFS_IIR_FCR, 32'h01);
    rd(5'h04, 32'h0);
    // Random modem control words; reserved bits must drop out.
    repeat (6) begin
      w = $random(seed);
      wr(`UMFC_OFS_MCR, w);
      rd(`UMFC_OFS_MCR, {27'h0, w[4], 2'b00, w[1:0]});
      check({30'h0, RTS, DTR}, {30'h0, w[1:0]});
    end
    // Every serial level combination with loopback off and on.
    for (int m = 1; m >= 0; m--) begin
      wr(`UMFC_OFS_MCR, m ? 32'h10 : 32'h0);
      for (int t = 0; t < 4; t++) begin
        @(posedge CLK);
        TX_SERIAL <= t[0];
        umfc_modem_model_i.sin <= t[1];
        @(negedge CLK);
        check({30'h0, RX_SERIAL, SOUT}, m ? {30'h0, t[0], 1'b1} : {30'h0, t[1], t[0]});
      end
    end
    // A write without its low byte lane is dropped; then a reset in mid-run.
    @(posedge CLK);
    BYTEENABLE <= 4'h0;
    wr(`UMFC_OFS_MCR, 32'h13);
    BYTEENABLE <= 4'hF;
    rd(`UMFC_OFS_MCR, 32'h0);
    wr(`UMFC_OFS_MCR, 32'h13);
    RST_B <= 1'b0;
    repeat (3) @(posedge CLK);
    RST_B <= 1'b1;
    rd(`UMFC_OFS_MCR, 32'h0);
    check({30'h0, RTS, DTR}, 32'h0);
    // Scratch byte holds random values.
    repeat (4) begin
      w = $random(seed);
      wr(`UMFC_OFS_SCR, w);
      rd(`UMFC_OFS_SCR, {24'h0, w[7:0]});
    end
    // A slow modem echoes the flow-control lines.
    umfc_modem_model_i.lag = 5;
    wr(`UMFC_OFS_MCR, 32'h03);
    repeat (12) @(posedge CLK);
    rd(`UMFC_OFS_MSR, 32'h33);
    umfc_modem_model_i.lag = 0;
    umfc_modem_model_i.set_lines(4'h0);
    repeat (3) @(posedge CLK);
    rd(`UMFC_OFS_MSR, 32'h03);
    rd(`UMFC_OFS_MSR, 32'h00);
    umfc_modem_model_i.set_lines(4'hF);
    repeat (3) @(posedge CLK);
    check({28'h0, IRQ_CODE}, 32'h0);
    rd(`UMFC_OFS_MSR, 32'hFB);
    // The flags clear at the answer edge, so the code is looked at once it has settled.
    @(negedge CLK);
    check({28'h0, IRQ_CODE}, 32'h1);
    umfc_modem_model_i.set_lines(4'h0);
    repeat (3) @(posedge CLK);
    rd(`UMFC_OFS_MSR, 32'h0F);
    wr(`UMFC_OFS_MSR, 32'hFF);
    rd(`UMFC_OFS_MSR, 32'h00);
    // Priority of the interrupt sources.
    irq(1'b1, 1'b1, 5'd1, 4'h6);
    irq(1'b0, 1'b1, 5'd1, 4'h4);
    irq(1'b0, 1'b1, 5'd0, 4'h2);
    rd(`UMFC_OFS_IIR_FCR, 32'h02);
    irq(1'b0, 1'b0, 5'd0, 4'h1);
    // Queue enable with both flushes, which must last one cycle.
    wr(`UMFC_OFS_IIR_FCR, 32'h07);
    @(negedge CLK);
    check({29'h0, FIFO_ENABLE, TX_FLUSH, RX_FLUSH}, 32'h7);
    @(negedge CLK);
    check({29'h0, FIFO_ENABLE, TX_FLUSH, RX_FLUSH}, 32'h4);
    rd(`UMFC_OFS_IIR_FCR, 32'hC1);
    for (int k = 0; k < 4; k++) begin
      wr(`UMFC_OFS_IIR_FCR, {24'h0, k[1:0], 6'h01});
      @(negedge CLK);
      check({27'h0, RX_THRESHOLD}, {27'h0, thr[k]});
    end
    wr(`UMFC_OFS_IIR_FCR, 32'h41);
    irq(1'b0, 1'b0, 5'd8, 4'h4);
    irq(1'b0, 1'b0, 5'd7, 4'h1);
    // Idle receive queue below threshold: timeout only after the full count.
    tick();
    tick();
    irq(1'b0, 1'b0, 5'd7, 4'h1);
    tick();
    irq(1'b0, 1'b0, 5'd7, 4'hC);
    rd(`UMFC_OFS_IIR_FCR, 32'hCC);
    @(posedge CLK);
    RX_MOVED <= 1'b1;
    @(posedge CLK);
    RX_MOVED <= 1'b0;
    irq(1'b0, 1'b0, 5'd0, 4'h1);
    // Disabling flushes both queues and ignores the other bits.
    wr(`UMFC_OFS_IIR_FCR, 32'hC6);
    @(negedge CLK);
    check({29'h0, FIFO_ENABLE, TX_FLUSH, RX_FLUSH}, 32'h3);
    check({27'h0, RX_THRESHOLD}, 32'h08);
    wr(`UMFC_OFS_IIR_FCR, 32'h06);
    @(negedge CLK);
    check({29'h0, FIFO_ENABLE, TX_FLUSH, RX_FLUSH}, 32'h0);
    rd(`UMFC_OFS_IIR_FCR, 32'h01);
    results();
  end
endmodule
